// [bench/lsc_lane_regs_bench.sv]
// Self-checking bench of the low-speed lane configuration bank
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %0t got %h want %h", $time, g, e); end end
module lsc_lane_regs_bench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic pwr_n = 1'b1;
	logic [3:0] pstrb = 4'hF;
	logic [3:0] pll_code;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	lsc_pkg::lsc_lane_ctrl_t [3:0] lane_ctrl;
	logic [7:0] pll_x2;
	logic pll_rsvd;
	int num_errors = 0;
	int checked = 0;
	bit bus_idle = 1'b1;
	logic [15:0] cfg_m [4];
	logic [15:0] pol_m [4];
	logic [31:0] rd;
	logic err;
	logic [15:0] c;
	logic [15:0] p;
	logic [3:0] codes [6] = '{4'h5, 4'h6, 4'h7, 4'hD, 4'hE, 4'hF};
	logic [7:0] facs [6] = '{8'h14, 8'h18, 8'h19, 8'h64, 8'h82, 8'h00};

	always #2.5 mclk = ~mclk;

	lsc_lane_regs #(.NUM_LANES(4), .ADDR_W(8)) i_dut (
		.mclk_i(mclk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .transceiver_powerdown_n_i(pwr_n), .lane_ctrl_o(lane_ctrl),
		.pll_multiplier_code_o(pll_code), .pll_factor_x2_o(pll_x2), .pll_code_reserved_o(pll_rsvd));

	// ----------------------------------------------------------------
	// Bus tasks and expectations
	// ----------------------------------------------------------------
	// A transfer that is not last keeps psel up so the next setup follows at once
	task automatic xfer(input logic wr_en, input logic [5:0] idx, input logic [31:0] wd, input logic last);
		int n;
		n = 0;
		if (bus_idle) @(posedge mclk);
		bus_idle = last;
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		// Ready and data are read as sampled at the edge, before the slave's own update lands
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			$display("MISMATCH %0t no ready", $time);
			summarize();
		end
		rd = prdata;
		err = pslverr;
		penable <= 1'b0;
		if (last) psel <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		xfer(1'b1, idx, {16'h0, d}, 1'b1);
		`CHK(err, 1'b0)
	endtask : wr

	function automatic lsc_pkg::lsc_lane_ctrl_t exp_ctrl(input logic [15:0] c, input logic [15:0] p,
		input logic ioff, input logic ooff);
		lsc_pkg::lsc_lane_ctrl_t e;
		e.output_amplitude_code = c[14:12];
		e.signal_loss_detect_enable = c[11];
		e.input_lane_enable = c[10] & ~ioff;
		e.input_lane_rate = lsc_pkg::lsc_rate_t'(c[9:8]);
		e.input_rate_reserved = (c[9:8] == 2'h3);
		e.output_deemphasis_code = c[7:4];
		e.output_lane_enable = c[2] & ~ooff;
		e.output_lane_rate = lsc_pkg::lsc_rate_t'(c[1:0]);
		e.output_rate_reserved = (c[1:0] == 2'h3);
		e.output_polarity_swap = p[15];
		e.input_polarity_swap = p[14];
		e.equalizer_code = p[11:8];
		e.equalizer_adaptive = (p[11:8] == 4'h1) | p[11];
		e.equalizer_reserved = (p[11:8] >= 4'h2) & ~p[11];
		e.clock_recovery_loop_mode = p[6:4];
		e.clock_recovery_reserved = (p[6:5] == 2'h3);
		e.transmit_test_mode = p[3];
		e.receive_test_mode = p[2];
		return e;
	endfunction : exp_ctrl

	// Reads every lane back under a one-hot mask, then the effective enables
	task automatic check_lanes(input logic [3:0] ioff, input logic [3:0] ooff);
		logic [7:0] en;
		for (int k = 0; k < 4; k++) begin
			xfer(1'b1, lsc_pkg::IDX_PLL_LANE_SEL, {16'h0, 4'h1 << k, 12'h005}, 1'b0);
			xfer(1'b0, lsc_pkg::IDX_OUT_IN_CFG, 32'h0, 1'b0);
			`CHK(rd, {16'h0, cfg_m[k]})
			xfer(1'b0, lsc_pkg::IDX_POL_EQ, 32'h0, 1'b0);
			`CHK(rd, {16'h0, pol_m[k]})
			`CHK(lane_ctrl[k], exp_ctrl(cfg_m[k], pol_m[k], ioff[k], ooff[k]))
			en[k] = cfg_m[k][10] & ~ioff[k];
			en[k + 4] = cfg_m[k][2] & ~ooff[k];
		end
		xfer(1'b0, lsc_pkg::IDX_LANE_STATUS, 32'h0, 1'b1);
		`CHK(rd, {22'h0, 1'b0, pwr_n, en})
	endtask : check_lanes

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize

	initial begin
		#100000;
		num_errors++;
		$display("MISMATCH %0t watchdog expired", $time);
		summarize();
	end

	initial begin
		for (int k = 0; k < 4; k++) begin
			cfg_m[k] = 16'hDC04;
			pol_m[k] = 16'h0001;
		end
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		check_lanes(4'h0, 4'h0);
		$display("Test reset values done");
		wr(lsc_pkg::IDX_PLL_LANE_SEL, 16'h1005);
		for (int i = 0; i < 16; i++) begin
			// Reserved bits keep their reset values; i = 3 sets both test bits as far-side loopback needs
			c = {1'b1, i[2:0], i[0], 1'b1, i[1:0], i[3:0], 1'b0, 1'b1, i[1:0]};
			p = {i[0], i[1], 2'b00, i[3:0], 1'b0, i[2:0], i[0], i[1], 2'b01};
			wr(lsc_pkg::IDX_OUT_IN_CFG, c);
			wr(lsc_pkg::IDX_POL_EQ, p);
			@(negedge mclk);
			@(negedge mclk);
			`CHK(lane_ctrl[0], exp_ctrl(c, p, 1'b0, 1'b0))
		end
		cfg_m[0] = c;
		pol_m[0] = p;
		check_lanes(4'h0, 4'h0);
		$display("Test field codes done");
		for (int j = 0; j < 6; j++) begin
			wr(lsc_pkg::IDX_PLL_LANE_SEL, {12'h100, codes[j]});
			@(negedge mclk);
			@(negedge mclk);
			`CHK(pll_code, codes[j])
			`CHK(pll_x2, facs[j])
			`CHK(pll_rsvd, codes[j] == 4'hF)
		end
		$display("Test multiplier codes done");
		wr(lsc_pkg::IDX_GLOBAL_CTRL, 16'h8000);
		check_lanes(4'hF, 4'hF);
		wr(lsc_pkg::IDX_GLOBAL_CTRL, 16'h0001);
		check_lanes(4'hC, 4'h0);
		wr(lsc_pkg::IDX_GLOBAL_CTRL, 16'h0002);
		check_lanes(4'h0, 4'hC);
		wr(lsc_pkg::IDX_GLOBAL_CTRL, 16'h0003);
		check_lanes(4'h0, 4'h0);
		wr(lsc_pkg::IDX_GLOBAL_CTRL, 16'h0000);
		pwr_n <= 1'b0;
		repeat (4) @(posedge mclk);
		check_lanes(4'hF, 4'hF);
		pwr_n <= 1'b1;
		repeat (4) @(posedge mclk);
		check_lanes(4'h0, 4'h0);
		$display("Test forced disables done");
		wr(lsc_pkg::IDX_PLL_LANE_SEL, 16'h0005);
		wr(lsc_pkg::IDX_OUT_IN_CFG, 16'h8000);
		wr(lsc_pkg::IDX_PLL_LANE_SEL, 16'hA005);
		wr(lsc_pkg::IDX_OUT_IN_CFG, 16'hA7F2);
		wr(lsc_pkg::IDX_POL_EQ, 16'hCA69);
		cfg_m[1] = 16'hA7F2;
		cfg_m[3] = 16'hA7F2;
		pol_m[1] = 16'hCA69;
		pol_m[3] = 16'hCA69;
		check_lanes(4'h0, 4'h0);
		wr(lsc_pkg::IDX_PLL_LANE_SEL, 16'hA005);
		xfer(1'b0, lsc_pkg::IDX_OUT_IN_CFG, 32'h0, 1'b1);
		`CHK({err, rd}, 33'h000000000)
		pstrb <= 4'h1;
		wr(lsc_pkg::IDX_OUT_IN_CFG, 16'h0000);
		pstrb <= 4'hF;
		cfg_m[1] = 16'hA700;
		cfg_m[3] = 16'hA700;
		check_lanes(4'h0, 4'h0);
		$display("Test lane mask done");
		xfer(1'b0, 6'h3F, 32'h0, 1'b1);
		`CHK({err, rd}, 33'h100000000)
		xfer(1'b1, lsc_pkg::IDX_LANE_STATUS, 32'h0000FFFF, 1'b1);
		`CHK(err, 1'b1)
		$display("Test refusals done");
		summarize();
	end
endmodule : lsc_lane_regs_bench

// [bench/lsc_lane_regs_properties.sv]
// Checker of the lane configuration bank port behaviour
`timescale 1ns/1ps
module lsc_lane_regs_properties #(
	parameter int NUM_LANES = 4,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input logic mclk_i,
	input logic rst_i,
	// APB
	input logic psel_i,
	input logic penable_i,
	input logic [31:0] prdata_o,
	input logic pready_o,
	input logic pslverr_o,
	// Pin and lane outputs
	input logic transceiver_powerdown_n_i,
	input lsc_pkg::lsc_lane_ctrl_t [NUM_LANES-1:0] lane_ctrl_o,
	input logic [3:0] pll_multiplier_code_o,
	input logic [7:0] pll_factor_x2_o,
	input logic pll_code_reserved_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	logic [NUM_LANES-1:0] in_en;
	logic [NUM_LANES-1:0] out_en;
	logic [7:0] exp_x2;
	logic known;
	always_comb begin
		for (int k = 0; k < NUM_LANES; k++) begin
			in_en[k] = lane_ctrl_o[k].input_lane_enable;
			out_en[k] = lane_ctrl_o[k].output_lane_enable;
		end
	end
	// Only codes 5, 6, 7, D, E and F, the ones the bench drives, are judged
	always_comb begin
		known = 1'b1;
		case (pll_multiplier_code_o)
			4'h5: exp_x2 = 8'h14;
			4'h6: exp_x2 = 8'h18;
			4'h7: exp_x2 = 8'h19;
			4'hD: exp_x2 = 8'h64;
			4'hE: exp_x2 = 8'h82;
			4'hF: exp_x2 = 8'h00;
			default: begin
				exp_x2 = 8'h00;
				known = 1'b0;
			end
		endcase
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	ready_after_setup_a: assert property (psel_i && !penable_i |-> !pready_o ##1 !pready_o ##1 pready_o)
		else $error("ready not two cycles after setup");
	ready_one_cycle_a: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	idle_data_zero_a: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside answer");
	upper_half_zero_a: assert property (pready_o |-> prdata_o[31:16] == 16'h0)
		else $error("upper read half not zero");
	err_with_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	in_pin_off_a: assert property (!transceiver_powerdown_n_i [*3] |=> in_en == '0)
		else $error("input lane on while pin low");
	out_pin_off_a: assert property (!transceiver_powerdown_n_i [*3] |=> out_en == '0)
		else $error("output lane on while pin low");
	enable_needs_pin_a: assert property ((|in_en) || (|out_en) |-> $past(transceiver_powerdown_n_i, 3))
		else $error("lane on without pin high");
	pll_decode_a: assert property (known |-> pll_factor_x2_o == exp_x2 &&
		pll_code_reserved_o == (pll_multiplier_code_o == 4'hF))
		else $error("pll factor decode wrong");
	cdr_reserved_a: assert property (lane_ctrl_o[0].clock_recovery_reserved ==
		(lane_ctrl_o[0].clock_recovery_loop_mode[2:1] == 2'h3))
		else $error("recovery reserved flag wrong");
	eq_adaptive_a: assert property (lane_ctrl_o[0].equalizer_adaptive ==
		(lane_ctrl_o[0].equalizer_code == 4'h1 || lane_ctrl_o[0].equalizer_code[3]))
		else $error("equalizer adaptive flag wrong");
endmodule : lsc_lane_regs_properties

bind lsc_lane_regs lsc_lane_regs_properties #(.NUM_LANES(NUM_LANES), .ADDR_W(ADDR_W)) i_props (
	.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .transceiver_powerdown_n_i(transceiver_powerdown_n_i),
	.lane_ctrl_o(lane_ctrl_o), .pll_multiplier_code_o(pll_multiplier_code_o),
	.pll_factor_x2_o(pll_factor_x2_o), .pll_code_reserved_o(pll_code_reserved_o));

// [hw/lsc_lane_regs.sv]
// Low-speed lane configuration register bank with APB slave and derived lane controls
`timescale 1ns/1ps
// What this block does
// - Decode PLL multiplier codes, 0011/1011/1100/1111 reserved
// - Output amplitude field bits 14:12, reset 101
// - Bit 11 enables loss-of-signal detection, reset one
// - Input enable forced off by pin, power-down
// - Two-to-one mode disables input lanes 3, 2
// - Input rate full/half/quarter, 11 reserved
// - De-emphasis field bits 7:4, reset 0000
// - Output enable forced off by pin, power-down
// - One-to-two mode disables output lanes 3, 2
// - Output rate full/half/quarter, 11 reserved
// - Bit 15 swaps output lane polarity
// - Bit 14 inverts input pair polarity
// - Equalizer field bits 11:8, decoded modes
// - Clock-recovery field bits 6:4, 11x reserved
// - Bit 3 puts transmit path in test
// - Bit 2 puts receive path in test
// - Reset reads 0xDC04 and 0x0001, all RW
// - Writes hit masked lanes, reads one-hot lane
module lsc_lane_regs #(
	parameter int NUM_LANES = 4,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Device pin, asynchronous
	input wire logic transceiver_powerdown_n_i,
	// Lane controls
	output lsc_pkg::lsc_lane_ctrl_t [NUM_LANES-1:0] lane_ctrl_o,
	// PLL multiplier decode, factor times two
	output logic [3:0] pll_multiplier_code_o,
	output logic [7:0] pll_factor_x2_o,
	output logic pll_code_reserved_o
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (NUM_LANES != 4) begin : g_bad_lanes
		$error("lsc_lane_regs: lane mask is four bits, NUM_LANES must be 4");
	end
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
		$error("lsc_lane_regs: ADDR_W must lie in 8..32");
	end

	// ----------------------------------------------------------------
	// Decoding functions
	// ----------------------------------------------------------------
	// Returns factor times two so that 12.5x stays an integer; zero marks a reserved code
	function automatic logic [7:0] pll_factor_x2(input logic [3:0] code);
		logic [7:0] f;
		f = 8'h00;
		case (code)
			4'h0: f = 8'h08;
			4'h1: f = 8'h0A;
			4'h2: f = 8'h0C;
			4'h4: f = 8'h10;
			4'h5: f = 8'h14;
			4'h6: f = 8'h18;
			4'h7: f = 8'h19;
			4'h8: f = 8'h1E;
			4'h9: f = 8'h28;
			4'hA: f = 8'h32;
			4'hD: f = 8'h64;
			4'hE: f = 8'h82;
			default: f = 8'h00;
		endcase
		return f;
	endfunction : pll_factor_x2

	function automatic logic [$clog2(NUM_LANES)-1:0] onehot_index(input logic [NUM_LANES-1:0] m);
		logic [$clog2(NUM_LANES)-1:0] idx;
		idx = '0;
		for (int i = 0; i < NUM_LANES; i++) begin
			if (m[i]) begin
				idx = i[$clog2(NUM_LANES)-1:0];
			end
		end
		return idx;
	endfunction : onehot_index

	function automatic logic [15:0] merge_bytes(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [15:0] v;
		v = old;
		if (strb[0]) begin
			v[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			v[15:8] = wd[15:8];
		end
		return v;
	endfunction : merge_bytes

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	// Reads as powered down until two edges have seen the pin, so lanes stay off that long after reset
	logic pd_n_meta_r;
	logic pd_n_sync_r;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pd_n_meta_r <= 1'b0;
			pd_n_sync_r <= 1'b0;
		end else begin
			pd_n_meta_r <= transceiver_powerdown_n_i;
			pd_n_sync_r <= pd_n_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic [5:0] reg_idx;
	logic word_aligned;
	logic hit_global;
	logic hit_status;
	logic hit_pll;
	logic hit_cfg;
	logic hit_pol;
	logic mapped;
	logic access;
	logic commit;
	logic wr_commit;
	logic upper_zero;

	// Address bits above the map must be zero, so no alias ever reaches a register
	if (ADDR_W > 8) begin : g_upper
		assign upper_zero = (paddr_i[ADDR_W-1:8] == '0);
	end else begin : g_no_upper
		assign upper_zero = 1'b1;
	end

	assign reg_idx = paddr_i[7:2];
	assign word_aligned = (paddr_i[1:0] == 2'h0) && upper_zero;
	assign hit_global = word_aligned && (reg_idx == lsc_pkg::IDX_GLOBAL_CTRL);
	assign hit_status = word_aligned && (reg_idx == lsc_pkg::IDX_LANE_STATUS);
	assign hit_pll = word_aligned && (reg_idx == lsc_pkg::IDX_PLL_LANE_SEL);
	assign hit_cfg = word_aligned && (reg_idx == lsc_pkg::IDX_OUT_IN_CFG);
	assign hit_pol = word_aligned && (reg_idx == lsc_pkg::IDX_POL_EQ);
	assign mapped = hit_global || hit_status || hit_pll || hit_cfg || hit_pol;
	// One wait state: pready rises in the second access cycle, the transfer ends on that edge
	assign access = psel_i && penable_i && !pready_o;
	assign commit = psel_i && penable_i && pready_o;
	assign wr_commit = commit && pwrite_i && !pslverr_o;

	// ----------------------------------------------------------------
	// Global control and PLL / lane-select registers
	// ----------------------------------------------------------------
	logic global_pd_r;
	lsc_pkg::lsc_mode_t lane_mode_r;
	logic [NUM_LANES-1:0] lane_select_mask_r;
	logic [3:0] pll_code_r;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			global_pd_r <= lsc_pkg::RST_GLOBAL_PD;
			lane_mode_r <= lsc_pkg::lsc_mode_t'(lsc_pkg::RST_LANE_MODE);
		end else if (wr_commit && hit_global) begin
			if (pstrb_i[1]) begin
				global_pd_r <= pwdata_i[lsc_pkg::GLOBAL_PD_BIT];
			end
			if (pstrb_i[0]) begin
				lane_mode_r <= lsc_pkg::lsc_mode_t'(pwdata_i[lsc_pkg::LANE_MODE_LSB +: 2]);
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			lane_select_mask_r <= lsc_pkg::RST_LANE_MASK;
			pll_code_r <= lsc_pkg::RST_PLL_CODE;
		end else if (wr_commit && hit_pll) begin
			if (pstrb_i[1]) begin
				lane_select_mask_r <= pwdata_i[lsc_pkg::LANE_MASK_LSB +: NUM_LANES];
			end
			if (pstrb_i[0]) begin
				pll_code_r <= pwdata_i[lsc_pkg::PLL_CODE_LSB +: 4];
			end
		end
	end

	// ----------------------------------------------------------------
	// Per-lane storage
	// ----------------------------------------------------------------
	// Every bit, reserved ones included, is kept as written; software owns the reserved values
	logic [15:0] cfg_r [NUM_LANES];
	logic [15:0] pol_r [NUM_LANES];

	for (genvar l = 0; l < NUM_LANES; l++) begin : g_store
		always_ff @(posedge mclk_i) begin
			if (rst_i) begin
				cfg_r[l] <= lsc_pkg::RST_OUT_IN_CFG;
				pol_r[l] <= lsc_pkg::RST_POL_EQ;
			end else if (wr_commit && lane_select_mask_r[l]) begin
				if (hit_cfg) begin
					cfg_r[l] <= merge_bytes(cfg_r[l], pwdata_i, pstrb_i);
				end
				if (hit_pol) begin
					pol_r[l] <= merge_bytes(pol_r[l], pwdata_i, pstrb_i);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Derived lane controls
	// ----------------------------------------------------------------
	logic [NUM_LANES-1:0] in_en_eff;
	logic [NUM_LANES-1:0] out_en_eff;
	lsc_pkg::lsc_lane_ctrl_t [NUM_LANES-1:0] lane_nxt;

	for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
		logic forced_off;
		logic upper_lane;
		assign forced_off = !pd_n_sync_r || global_pd_r;
		assign upper_lane = (l >= 2);
		// Forcing acts here only; the stored enable bits stay untouched
		assign in_en_eff[l] = cfg_r[l][lsc_pkg::IN_EN_BIT] && !forced_off
			&& !(upper_lane && lane_mode_r == lsc_pkg::LSC_MODE_TWO_TO_ONE);
		assign out_en_eff[l] = cfg_r[l][lsc_pkg::OUT_EN_BIT] && !forced_off
			&& !(upper_lane && lane_mode_r == lsc_pkg::LSC_MODE_ONE_TO_TWO);

		always_comb begin
			lane_nxt[l] = '0;
			lane_nxt[l].output_amplitude_code = cfg_r[l][lsc_pkg::AMP_LSB +: 3];
			lane_nxt[l].signal_loss_detect_enable = cfg_r[l][lsc_pkg::LOS_BIT];
			lane_nxt[l].input_lane_enable = in_en_eff[l];
			lane_nxt[l].input_lane_rate = lsc_pkg::lsc_rate_t'(cfg_r[l][lsc_pkg::IN_RATE_LSB +: 2]);
			lane_nxt[l].input_rate_reserved = (lane_nxt[l].input_lane_rate == lsc_pkg::LSC_RATE_RSVD);
			lane_nxt[l].output_deemphasis_code = cfg_r[l][lsc_pkg::DEEMPH_LSB +: 4];
			lane_nxt[l].output_lane_enable = out_en_eff[l];
			lane_nxt[l].output_lane_rate = lsc_pkg::lsc_rate_t'(cfg_r[l][lsc_pkg::OUT_RATE_LSB +: 2]);
			lane_nxt[l].output_rate_reserved = (lane_nxt[l].output_lane_rate == lsc_pkg::LSC_RATE_RSVD);
			lane_nxt[l].output_polarity_swap = pol_r[l][lsc_pkg::OUT_SWAP_BIT];
			lane_nxt[l].input_polarity_swap = pol_r[l][lsc_pkg::IN_SWAP_BIT];
			lane_nxt[l].equalizer_code = pol_r[l][lsc_pkg::EQ_LSB +: 4];
			lane_nxt[l].equalizer_adaptive = (lane_nxt[l].equalizer_code == lsc_pkg::EQ_ADAPTIVE)
				|| lane_nxt[l].equalizer_code[3];
			lane_nxt[l].equalizer_reserved = !lane_nxt[l].equalizer_code[3]
				&& (lane_nxt[l].equalizer_code[2:1] != 2'h0);
			lane_nxt[l].clock_recovery_loop_mode = pol_r[l][lsc_pkg::CDR_LSB +: 3];
			lane_nxt[l].clock_recovery_reserved =
				(lane_nxt[l].clock_recovery_loop_mode[2:1] == lsc_pkg::CDR_RSVD_TOP);
			// Far-side loopback only works with both test bits set; this block passes them as written
			lane_nxt[l].transmit_test_mode = pol_r[l][lsc_pkg::TX_TEST_BIT];
			lane_nxt[l].receive_test_mode = pol_r[l][lsc_pkg::RX_TEST_BIT];
		end
	end

	// Registered so that every lane output changes one cycle after the registers it decodes (three after the pin), never glitches
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			lane_ctrl_o <= '0;
		end else begin
			lane_ctrl_o <= lane_nxt;
		end
	end

	// ----------------------------------------------------------------
	// PLL multiplier decode
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pll_multiplier_code_o <= 4'h0;
			pll_factor_x2_o <= 8'h00;
			pll_code_reserved_o <= 1'b0;
		end else begin
			pll_multiplier_code_o <= pll_code_r;
			pll_factor_x2_o <= pll_factor_x2(pll_code_r);
			pll_code_reserved_o <= (pll_factor_x2(pll_code_r) == 8'h00);
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	logic [31:0] rdata_nxt;
	logic sel_onehot;
	logic [$clog2(NUM_LANES)-1:0] sel_lane;

	assign sel_onehot = $onehot(lane_select_mask_r);
	assign sel_lane = onehot_index(lane_select_mask_r);

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (hit_global) begin
			rdata_nxt[lsc_pkg::GLOBAL_PD_BIT] = global_pd_r;
			rdata_nxt[lsc_pkg::LANE_MODE_LSB +: 2] = lane_mode_r;
		end else if (hit_status) begin
			rdata_nxt[0 +: NUM_LANES] = in_en_eff;
			rdata_nxt[lsc_pkg::STAT_OUT_EN_LSB +: NUM_LANES] = out_en_eff;
			rdata_nxt[lsc_pkg::STAT_PIN_BIT] = pd_n_sync_r;
			rdata_nxt[lsc_pkg::STAT_PLL_RSVD_BIT] = (pll_factor_x2(pll_code_r) == 8'h00);
		end else if (hit_pll) begin
			rdata_nxt[lsc_pkg::LANE_MASK_LSB +: NUM_LANES] = lane_select_mask_r;
			rdata_nxt[lsc_pkg::PLL_CODE_LSB +: 4] = pll_code_r;
		end else if (hit_cfg && sel_onehot) begin
			rdata_nxt[15:0] = cfg_r[sel_lane];
		end else if (hit_pol && sel_onehot) begin
			rdata_nxt[15:0] = pol_r[sel_lane];
		end
	end

	// ----------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else if (access) begin
			pready_o <= 1'b1;
			// Status is read-only, so a write to it is refused like an unmapped address
			pslverr_o <= !mapped || (pwrite_i && hit_status);
			prdata_o <= pwrite_i ? 32'h0000_0000 : rdata_nxt;
		end else begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end
	end

endmodule : lsc_lane_regs

// [include/lsc_pkg.sv]
// Package: constants, register map and carrier types of the low-speed lane configuration bank
package lsc_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_GLOBAL_CTRL = 6'h01;
	localparam logic [5:0] IDX_LANE_STATUS = 6'h02;
	localparam logic [5:0] IDX_PLL_LANE_SEL = 6'h06;
	localparam logic [5:0] IDX_OUT_IN_CFG = 6'h07;
	localparam logic [5:0] IDX_POL_EQ = 6'h08;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_OUT_IN_CFG = 16'hDC04;
	localparam logic [15:0] RST_POL_EQ = 16'h0001;
	localparam logic [3:0] RST_PLL_CODE = 4'h5;
	localparam logic [3:0] RST_LANE_MASK = 4'hF;
	localparam logic RST_GLOBAL_PD = 1'b0;
	localparam logic [1:0] RST_LANE_MODE = 2'h0;

	// ----------------------------------------------------------------
	// Field positions, output/input configuration register
	// ----------------------------------------------------------------
	localparam int AMP_LSB = 12;
	localparam int LOS_BIT = 11;
	localparam int IN_EN_BIT = 10;
	localparam int IN_RATE_LSB = 8;
	localparam int DEEMPH_LSB = 4;
	localparam int OUT_EN_BIT = 2;
	localparam int OUT_RATE_LSB = 0;

	// ----------------------------------------------------------------
	// Field positions, polarity/equalizer register
	// ----------------------------------------------------------------
	localparam int OUT_SWAP_BIT = 15;
	localparam int IN_SWAP_BIT = 14;
	localparam int EQ_LSB = 8;
	localparam int CDR_LSB = 4;
	localparam int TX_TEST_BIT = 3;
	localparam int RX_TEST_BIT = 2;

	// ----------------------------------------------------------------
	// Field positions, global control, PLL/lane-select and status
	// ----------------------------------------------------------------
	localparam int GLOBAL_PD_BIT = 15;
	localparam int LANE_MODE_LSB = 0;
	localparam int LANE_MASK_LSB = 12;
	localparam int PLL_CODE_LSB = 0;
	localparam int STAT_OUT_EN_LSB = 4;
	localparam int STAT_PIN_BIT = 8;
	localparam int STAT_PLL_RSVD_BIT = 9;

	// ----------------------------------------------------------------
	// Codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LSC_RATE_FULL = 2'h0,
		LSC_RATE_HALF = 2'h1,
		LSC_RATE_QUARTER = 2'h2,
		LSC_RATE_RSVD = 2'h3
	} lsc_rate_t;

	typedef enum logic [1:0] {
		LSC_MODE_NORMAL = 2'h0,
		LSC_MODE_TWO_TO_ONE = 2'h1,
		LSC_MODE_ONE_TO_TWO = 2'h2
	} lsc_mode_t;

	localparam logic [3:0] EQ_ADAPTIVE = 4'h1;
	localparam logic [1:0] CDR_RSVD_TOP = 2'h3;

	// ----------------------------------------------------------------
	// Per-lane control carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] output_amplitude_code;
		logic signal_loss_detect_enable;
		logic input_lane_enable;
		lsc_rate_t input_lane_rate;
		logic input_rate_reserved;
		logic [3:0] output_deemphasis_code;
		logic output_lane_enable;
		lsc_rate_t output_lane_rate;
		logic output_rate_reserved;
		logic output_polarity_swap;
		logic input_polarity_swap;
		logic [3:0] equalizer_code;
		logic equalizer_adaptive;
		logic equalizer_reserved;
		logic [2:0] clock_recovery_loop_mode;
		logic clock_recovery_reserved;
		logic transmit_test_mode;
		logic receive_test_mode;
	} lsc_lane_ctrl_t;

endpackage : lsc_pkg
